// >>> cbc_addr_filter.sv
// Purpose: Forwarding decision for host I/O and memory addresses
// Assumes: Address is a 32-bit host address, qualified by is_io
// Notes: Combinational; the caller registers the result
`timescale 1ns/1ps
module cbc_addr_filter (
    // Address
    input wire logic [31:0] addr_i,
    input wire logic is_io_i,
    // Controls
    input wire logic vga_en_i,
    input wire logic isa_en_i,
    input wire logic [31:0] legacy_base_i,
    // Results
    output logic vga_hit_o,
    output logic isa_block_o,
    output logic legacy_index_o,
    output logic legacy_data_o
);
    logic vga_mem;
    logic vga_io;
    always_comb begin
        vga_mem = !is_io_i && addr_i >= 32'h000A_0000 && addr_i <= 32'h000B_FFFF;
        vga_io = is_io_i && addr_i[31:16] == 16'h0000
            && ((addr_i[9:0] >= 10'h3B0 && addr_i[9:0] <= 10'h3BB)
            || (addr_i[9:0] >= 10'h3C0 && addr_i[9:0] <= 10'h3DF));
        vga_hit_o = vga_en_i && (vga_mem || vga_io);
        // Upper 768 bytes of each 1K in the low 64K
        isa_block_o = isa_en_i && is_io_i && addr_i[31:16] == 16'h0000
            && addr_i[9:8] != 2'b00;
        legacy_index_o = is_io_i && addr_i == {legacy_base_i[31:1], 1'b0};
        legacy_data_o = is_io_i && addr_i == {legacy_base_i[31:1], 1'b1};
    end
endmodule // cbc_addr_filter

// >>> cbc_card_model.sv
// Purpose: Card-side event source for the bridge config group
// Assumes: Event request held one cycle by the bench
// Notes: A card held in reset raises no events
`timescale 1ns/1ps
module cbc_card_model (
    // Clock and card reset
    input wire logic ref_clk_i,
    input wire logic card_reset_i,
    // Requests: bit 0 abort, 1 system error, 2 parity
    input wire logic [2:0] ev_i,
    input wire logic [3:0] lag_i,
    // Card events
    output logic master_abort_o,
    output logic system_error_o,
    output logic parity_error_o
);
    logic [2:0] ev_hold;
    initial {parity_error_o, system_error_o, master_abort_o} = 3'h0;
    always @(posedge ref_clk_i) begin
        if (ev_i != 3'h0 && !card_reset_i) begin
            // Latch the request; it is gone before the lag runs out
            ev_hold = ev_i;
            repeat (lag_i) @(posedge ref_clk_i);
            {parity_error_o, system_error_o, master_abort_o} <= ev_hold;
            @(posedge ref_clk_i);
            {parity_error_o, system_error_o, master_abort_o} <= 3'h0;
        end
    end
endmodule // cbc_card_model

// >>> cbc_config_regs.sv
// Purpose: Card bridge configuration register group
// Assumes: Host config strobes and card events are synchronous to ref_clk_i
// Notes: Global reset loads all reset values; host bus reset spares the card reset bit
//
// Behaviour
// - Pin register 01h; function 1 depends tie
// - Tie bit merges second interrupt onto first
// - Bridge bits 15-11 and 4 read zero
// - Bit 10 enables burst write posting
// - Bits 9,8 select window prefetchability
// - Bit 7 routes card functional interrupts
// - Bit 6 drives card reset, global reset sets
// - Host bus reset also asserts card reset
// - Card reset bit kept through host bus reset
// - Bit 5 turns master abort into target abort
// - Bit 3 forwards VGA addresses to card
// - Bit 2 blocks upper 768 of 1K
// - Bit 1 forwards card system error to SERR
// - Bit 0 reports card parity errors
// - Subsystem ids writable only while unlocked
// - Subsystem ids load from ROM after reset
// - Legacy base is index, base+1 data
// - Legacy base bit 0 reads one
`timescale 1ns/1ps
module cbc_config_regs (
    // Clock and resets
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic host_bus_reset_n_i,
    // Config access
    input wire cbc_pkg::cbc_cfg_req_t cfg_req_i,
    input wire logic cfg_func_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_ack_o,
    // Optional ROM load
    input wire logic rom_present_i,
    input wire logic rom_valid_i,
    input wire logic [15:0] rom_vendor_i,
    input wire logic [15:0] rom_sub_id_i,
    // Interrupts
    input wire logic int_line_a_i,
    input wire logic int_line_b_i,
    output logic int_a_o,
    output logic int_b_o,
    // Card side events
    input wire logic card_master_abort_i,
    input wire logic card_system_error_i,
    input wire logic card_parity_error_i,
    input wire logic serr_enable_i,
    output logic host_target_abort_o,
    output logic host_serr_o,
    output logic card_parity_error_o,
    output logic card_reset_out_o,
    // Address filter
    input wire logic [31:0] fwd_addr_i,
    input wire logic fwd_is_io_i,
    output logic vga_forward_o,
    output logic isa_block_o,
    output logic legacy_index_hit_o,
    output logic legacy_data_hit_o,
    output cbc_pkg::cbc_ctrl_t ctrl_o
);
    import cbc_pkg::*;

    typedef struct packed {
        cbc_bridge_t bridge;
        logic [31:0] sys_ctrl;
        logic [15:0] sub_vendor;
        logic [15:0] sub_id;
        logic [31:0] legacy;
        logic rom_wait;
        logic [31:0] rdata;
        logic ack;
        logic int_a;
        logic int_b;
        logic target_abort;
        logic serr;
        logic perr;
        logic card_reset;
        logic vga;
        logic isa;
        logic lidx;
        logic ldat;
        cbc_ctrl_t ctrl;
    } cbc_state_t;

    cbc_state_t state_reg;
    cbc_state_t state_next;
    logic vga_hit;
    logic isa_hit;
    logic lidx_hit;
    logic ldat_hit;

    // Byte-enable merge of a write into a word
    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] be, input logic [31:0] wmask);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge_be = (res & wmask) | (old_v & ~wmask);
    endfunction

    cbc_addr_filter u_filter (
        .addr_i(fwd_addr_i),
        .is_io_i(fwd_is_io_i),
        .vga_en_i(state_reg.bridge.vga_forward_enable),
        .isa_en_i(state_reg.bridge.isa_alias_filter_enable),
        .legacy_base_i(state_reg.legacy),
        .vga_hit_o(vga_hit),
        .isa_block_o(isa_hit),
        .legacy_index_o(lidx_hit),
        .legacy_data_o(ldat_hit)
    );

    always_comb begin
        logic [31:0] word;
        logic [31:0] bridge_word;
        logic unlocked;
        logic tie;
        word = 32'h0000_0000;
        bridge_word = 32'h0000_0000;
        state_next = state_reg;
        tie = state_reg.sys_ctrl[CBC_SYS_TIE_BIT];
        unlocked = !state_reg.sys_ctrl[CBC_SYS_UNLOCK_BIT];
        state_next.ack = cfg_req_i.rd || cfg_req_i.wr;

        // Reads: word at 3Ch holds line (unused, 0), pin, bridge control
        if (cfg_req_i.rd) begin
            unique case (cfg_req_i.addr)
                CBC_OFF_INT_PIN & 8'hFC: begin
                    word[15:8] = (cfg_func_i && !tie) ? CBC_PIN_LINE_B
                        : CBC_PIN_LINE_A;
                    if (!cfg_func_i) begin
                        word[31:16] = 16'(state_reg.bridge) & CBC_BRIDGE_WMASK;
                    end
                end
                CBC_OFF_SUB_VENDOR: word = {state_reg.sub_id, state_reg.sub_vendor};
                CBC_OFF_LEGACY: word = {state_reg.legacy[31:1], 1'b1};
                CBC_OFF_SYS_CTRL: word = state_reg.sys_ctrl;
                default: word = 32'h0000_0000;
            endcase
            state_next.rdata = word;
        end

        // Writes: function 0 only, dropped during host bus reset
        if (cfg_req_i.wr && !cfg_func_i && host_bus_reset_n_i) begin
            unique case (cfg_req_i.addr)
                CBC_OFF_INT_PIN & 8'hFC: begin
                    bridge_word = merge_be({16'(state_reg.bridge), 16'h0000},
                        cfg_req_i.wdata, cfg_req_i.be, {CBC_BRIDGE_WMASK, 16'h0000});
                    state_next.bridge = cbc_bridge_t'(bridge_word[31:16]);
                end
                CBC_OFF_SUB_VENDOR: begin
                    if (unlocked) begin
                        word = merge_be({state_reg.sub_id, state_reg.sub_vendor},
                            cfg_req_i.wdata, cfg_req_i.be, 32'hFFFF_FFFF);
                        state_next.sub_vendor = word[15:0];
                        state_next.sub_id = word[31:16];
                    end
                end
                CBC_OFF_LEGACY: begin
                    state_next.legacy = merge_be(state_reg.legacy, cfg_req_i.wdata,
                        cfg_req_i.be, CBC_LEGACY_WMASK);
                end
                CBC_OFF_SYS_CTRL: begin
                    state_next.sys_ctrl = merge_be(state_reg.sys_ctrl, cfg_req_i.wdata,
                        cfg_req_i.be, 32'hFFFF_FFFF);
                end
                default: begin
                end
            endcase
        end

        // ROM load after reset
        if (state_reg.rom_wait) begin
            if (!rom_present_i) begin
                state_next.rom_wait = 1'b0;
            end else if (rom_valid_i) begin
                state_next.sub_vendor = rom_vendor_i;
                state_next.sub_id = rom_sub_id_i;
                state_next.rom_wait = 1'b0;
            end
        end

        // Host bus reset: restores bridge control except card reset bit, and legacy base
        // Applied before card reset and ctrl are derived so they see the reset values
        if (!host_bus_reset_n_i) begin
            state_next.bridge = cbc_bridge_t'(CBC_BRIDGE_RESET);
            state_next.bridge.card_reset_ctl = state_reg.bridge.card_reset_ctl;
            state_next.legacy = CBC_LEGACY_RESET;
            state_next.ack = 1'b0;
            state_next.rdata = 32'h0000_0000;
        end

        // Interrupt merging
        state_next.int_a = int_line_a_i || (tie && int_line_b_i);
        state_next.int_b = int_line_b_i && !tie;

        // Card events
        state_next.target_abort = card_master_abort_i
            && state_reg.bridge.master_abort_report_mode;
        state_next.serr = serr_enable_i && ((card_master_abort_i
            && state_reg.bridge.master_abort_report_mode)
            || (card_system_error_i && state_reg.bridge.card_system_error_forward));
        state_next.perr = card_parity_error_i
            && state_reg.bridge.card_parity_error_report;

        state_next.card_reset = state_next.bridge.card_reset_ctl
            || !host_bus_reset_n_i;

        state_next.vga = vga_hit;
        state_next.isa = isa_hit;
        state_next.lidx = lidx_hit;
        state_next.ldat = ldat_hit;
        state_next.ctrl.write_post_enable = state_next.bridge.write_post_enable;
        state_next.ctrl.window1_prefetchable = state_next.bridge.window1_prefetchable;
        state_next.ctrl.window0_prefetchable = state_next.bridge.window0_prefetchable;
        state_next.ctrl.card_irq_route_select =
            state_next.bridge.card_irq_route_select;
        state_next.ctrl.master_abort_report_mode = state_next.bridge.master_abort_report_mode;
        state_next.ctrl.vga_forward_enable = state_next.bridge.vga_forward_enable;
        state_next.ctrl.isa_alias_filter_enable = state_next.bridge.isa_alias_filter_enable;
        state_next.ctrl.card_system_error_forward = state_next.bridge.card_system_error_forward;
        state_next.ctrl.card_parity_error_report = state_next.bridge.card_parity_error_report;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_reg <= '0;
            state_reg.bridge <= cbc_bridge_t'(CBC_BRIDGE_RESET);
            state_reg.sys_ctrl <= CBC_SYS_CTRL_RESET;
            state_reg.sub_vendor <= CBC_SUB_RESET;
            state_reg.sub_id <= CBC_SUB_RESET;
            state_reg.legacy <= CBC_LEGACY_RESET;
            state_reg.rom_wait <= 1'b1;
            state_reg.card_reset <= 1'b1;
            state_reg.ctrl.window1_prefetchable <= 1'b1;
            state_reg.ctrl.window0_prefetchable <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cfg_rdata_o = state_reg.rdata;
    assign cfg_ack_o = state_reg.ack;
    assign int_a_o = state_reg.int_a;
    assign int_b_o = state_reg.int_b;
    assign host_target_abort_o = state_reg.target_abort;
    assign host_serr_o = state_reg.serr;
    assign card_parity_error_o = state_reg.perr;
    assign card_reset_out_o = state_reg.card_reset;
    assign vga_forward_o = state_reg.vga;
    assign isa_block_o = state_reg.isa;
    assign legacy_index_hit_o = state_reg.lidx;
    assign legacy_data_hit_o = state_reg.ldat;
    assign ctrl_o = state_reg.ctrl;
endmodule // cbc_config_regs

// >>> cbc_config_regs_bench.sv
// Purpose: Self-checking bench for the card bridge config group
// Assumes: Reads answered one cycle after the request
// Notes: Read results are queued and compared on each ack
`timescale 1ns/1ps
module cbc_config_regs_bench;
    import cbc_pkg::*;
    logic ref_clk_i, reset_n_i, host_bus_reset_n_i, cfg_func_i, rom_present_i, rom_valid_i;
    logic int_line_a_i, int_line_b_i, serr_enable_i, fwd_is_io_i, cfg_ack_o, int_a_o, int_b_o;
    logic host_target_abort_o, host_serr_o, card_parity_error_o, card_reset_out_o;
    logic vga_forward_o, isa_block_o, legacy_index_hit_o, legacy_data_hit_o;
    logic card_master_abort_i, card_system_error_i, card_parity_error_i;
    logic [15:0] rom_vendor_i, rom_sub_id_i;
    logic [31:0] fwd_addr_i, cfg_rdata_o, r;
    logic [63:0] nt;
    logic [2:0] ev_cmd;
    logic [3:0] lag;
    cbc_cfg_req_t cfg_req_i;
    cbc_ctrl_t ctrl_o;
    logic [63:0] q[$];
    int n_errors = 0, n_checks = 0, cyc = 0;
    cbc_config_regs cbc_config_regs_i (.ref_clk_i, .reset_n_i, .host_bus_reset_n_i, .cfg_req_i,
        .cfg_func_i, .cfg_rdata_o, .cfg_ack_o, .rom_present_i, .rom_valid_i, .rom_vendor_i,
        .rom_sub_id_i, .int_line_a_i, .int_line_b_i, .int_a_o, .int_b_o, .card_master_abort_i,
        .card_system_error_i, .card_parity_error_i, .serr_enable_i, .host_target_abort_o,
        .host_serr_o, .card_parity_error_o, .card_reset_out_o, .fwd_addr_i, .fwd_is_io_i,
        .vga_forward_o, .isa_block_o, .legacy_index_hit_o, .legacy_data_hit_o, .ctrl_o);
    cbc_card_model cbc_card_model_i (.ref_clk_i, .card_reset_i(card_reset_out_o), .ev_i(ev_cmd),
        .lag_i(lag), .master_abort_o(card_master_abort_i), .system_error_o(card_system_error_i),
        .parity_error_o(card_parity_error_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic acc(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] m, logic [31:0] e,
            logic f);
        @(posedge ref_clk_i);
        cfg_req_i <= '{w, !w, a, 4'hF, d};
        cfg_func_i <= f;
        q.push_back({m, e});
        @(posedge ref_clk_i);
        cfg_req_i <= '0;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        acc(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e, logic f = 1'b0);
        acc(1'b0, a, 32'h0, m, e, f);
    endtask
    task automatic fwd(logic [31:0] a, logic io, logic [3:0] e);
        @(posedge ref_clk_i);
        fwd_addr_i <= a;
        fwd_is_io_i <= io;
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("forward", e, {vga_forward_o, isa_block_o, legacy_index_hit_o, legacy_data_hit_o});
    endtask
    task automatic ev(logic [2:0] k, logic [2:0] e);
        logic [2:0] seen;
        seen = 3'h0;
        @(posedge ref_clk_i);
        ev_cmd <= k;
        lag <= 4'($urandom_range(0, 4));
        @(posedge ref_clk_i);
        ev_cmd <= 3'h0;
        repeat (12) begin
            @(negedge ref_clk_i);
            seen |= {card_parity_error_o, host_serr_o, host_target_abort_o};
        end
        chk("events", e, seen);
    endtask
    task automatic global_reset();
        reset_n_i <= 1'b0;
        repeat (16) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
    endtask
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc > 4000) begin
            n_errors++;
            conclude();
        end
        if (cfg_ack_o === 1'b1) begin
            nt = (q.size() > 0) ? q.pop_front() : 64'h0;
            chk("read data", nt[31:0], cfg_rdata_o & nt[63:32]);
        end
    end
    initial begin
        reset_n_i = 1'b0; host_bus_reset_n_i = 1'b1; cfg_req_i = '0; cfg_func_i = 1'b0;
        rom_present_i = 1'b0; rom_valid_i = 1'b0; rom_vendor_i = 16'h0; rom_sub_id_i = 16'h0;
        int_line_a_i = 1'b0; int_line_b_i = 1'b0; serr_enable_i = 1'b1; fwd_addr_i = 32'h0;
        fwd_is_io_i = 1'b0; ev_cmd = 3'h0; lag = 4'h0;
        void'($urandom(77));
        global_reset();
        rd(8'h3C, '1, 32'h0340_0100);
        rd(8'h40, '1, 32'h0);
        rd(8'h44, '1, 32'h1);
        chk("card reset", 1, card_reset_out_o);
        chk("ctrl", 9'h0C0, ctrl_o);
        $display("reset values done");
        repeat (6) begin
            r = $urandom;
            wr(8'h3C, r);
            rd(8'h3C, '1, {r[31:16] & 16'h07EF, 16'h0100});
            chk("ctrl", {r[26:23], r[21], r[19:16]}, ctrl_o);
            chk("card reset", r[22], card_reset_out_o);
        end
        $display("bridge control done");
        for (int t = 0; t < 2; t++) begin
            // Serial irq routing taken as set before the tie
            wr(8'h80, 32'h0844_9060 | (32'(t) << 29));
            rd(8'h3C, 32'h0000_FF00, t ? 32'h0100 : 32'h0200, 1'b1);
            int_line_b_i <= 1'b1;
            repeat (3) @(posedge ref_clk_i);
            chk("merged line", t, int_a_o);
            chk("second line", !t, int_b_o);
            int_line_b_i <= 1'b0;
        end
        $display("interrupt tie done");
        r = $urandom | 32'h0001_0000;
        wr(8'h40, r);
        rd(8'h40, '1, 32'h0);
        wr(8'h80, 32'h0844_9040);
        wr(8'h40, r);
        rd(8'h40, '1, r);
        wr(8'h44, r);
        rd(8'h44, '1, r | 32'h1);
        $display("ids and legacy done");
        wr(8'h3C, 32'h000C_0000);
        fwd({r[31:1], 1'b0}, 1'b1, 4'b0010);
        fwd({r[31:1], 1'b1}, 1'b1, 4'b0001);
        fwd(32'h000A_0000, 1'b0, 4'b1000);
        fwd(32'h0000_0100, 1'b1, 4'b0100);
        fwd(32'h0000_04FF, 1'b1, 4'b0000);
        wr(8'h3C, 32'h0);
        fwd(32'h000A_0000, 1'b0, 4'b0000);
        fwd(32'h0000_0100, 1'b1, 4'b0000);
        $display("forwarding done");
        for (int en = 0; en < 3; en++) begin
            wr(8'h3C, en ? 32'h0023_0000 : 32'h0);
            serr_enable_i <= (en != 2);
            for (int k = 1; k < 8; k <<= 1) begin
                ev(3'(k), en ? {k[2], (k[1] | k[0]) && en == 1, k[0]} : 3'h0);
            end
        end
        $display("card events done");
        @(posedge ref_clk_i);
        host_bus_reset_n_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("card reset", 1, card_reset_out_o);
        @(posedge ref_clk_i);
        host_bus_reset_n_i <= 1'b1;
        rd(8'h3C, '1, 32'h0300_0100);
        @(negedge ref_clk_i);
        chk("card reset", 0, card_reset_out_o);
        @(posedge ref_clk_i);
        rom_present_i <= 1'b1;
        rom_vendor_i <= r[15:0];
        rom_sub_id_i <= r[31:16];
        global_reset();
        @(posedge ref_clk_i);
        rom_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        rom_valid_i <= 1'b0;
        rd(8'h40, '1, r);
        chk("card reset", 1, card_reset_out_o);
        $display("resets and rom done");
        repeat (4) @(posedge ref_clk_i);
        chk("acks left", 0, q.size());
        conclude();
    end
endmodule // cbc_config_regs_bench

// >>> cbc_config_regs_chk.sv
// Purpose: Port assertions for the card bridge config group
// Assumes: One clock, synchronous active-low global reset
// Notes: Bound onto cbc_config_regs
`timescale 1ns/1ps
module cbc_config_regs_chk (
    // Clock, resets, config
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic host_bus_reset_n_i,
    input wire cbc_pkg::cbc_cfg_req_t cfg_req_i,
    input wire logic cfg_func_i,
    input wire logic [31:0] cfg_rdata_o,
    // Card events and controls
    input wire logic card_master_abort_i,
    input wire logic card_system_error_i,
    input wire logic card_parity_error_i,
    input wire logic serr_enable_i,
    input wire logic host_target_abort_o,
    input wire logic host_serr_o,
    input wire logic card_parity_error_o,
    input wire logic card_reset_out_o,
    input wire cbc_pkg::cbc_ctrl_t ctrl_o
);
    import cbc_pkg::*;
    logic rd_f0;
    assign rd_f0 = cfg_req_i.rd && host_bus_reset_n_i && !cfg_func_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    rsvd_zero_a: assert property (rd_f0 && cfg_req_i.addr == 8'h3C |=>
        cfg_rdata_o[31:27] == 5'h00 && !cfg_rdata_o[20]) else $error("reserved bits set");
    pin_func0_a: assert property (rd_f0 && cfg_req_i.addr == 8'h3C |=>
        cfg_rdata_o[15:8] == 8'h01) else $error("pin value wrong");
    legacy_bit0_a: assert property (rd_f0 && cfg_req_i.addr == 8'h44 |=>
        cfg_rdata_o[0]) else $error("legacy bit 0 clear");
    host_card_reset_out_a: assert property (!host_bus_reset_n_i |=> card_reset_out_o)
        else $error("card reset not passed");
    abort_rep_a: assert property (
        card_master_abort_i && ctrl_o.master_abort_report_mode |-> ##1 host_target_abort_o)
        else $error("target abort missing");
    abort_quiet_a: assert property (
        !card_master_abort_i || !ctrl_o.master_abort_report_mode |=> !host_target_abort_o)
        else $error("spurious target abort");
    serr_fwd_a: assert property (
        card_system_error_i && ctrl_o.card_system_error_forward && serr_enable_i
        |=> host_serr_o)
        else $error("serr not forwarded");
    serr_quiet_a: assert property (
        !card_system_error_i && !card_master_abort_i |=> !host_serr_o)
        else $error("spurious serr");
    perr_rep_a: assert property (1'b1 |=> card_parity_error_o ==
        $past(card_parity_error_i && ctrl_o.card_parity_error_report))
        else $error("parity report wrong");
    cover property (cfg_req_i.wr && cfg_func_i);
    cover property (card_master_abort_i && ctrl_o.master_abort_report_mode);
    cover property (!host_bus_reset_n_i);
endmodule // cbc_config_regs_chk

bind cbc_config_regs cbc_config_regs_chk cbc_config_regs_chk_i (.ref_clk_i, .reset_n_i,
    .host_bus_reset_n_i, .cfg_req_i, .cfg_func_i, .cfg_rdata_o, .card_master_abort_i,
    .card_system_error_i, .card_parity_error_i, .serr_enable_i, .host_target_abort_o, .host_serr_o,
    .card_parity_error_o, .card_reset_out_o, .ctrl_o);

// >>> cbc_pkg.sv
// Purpose: Shared constants and carriers for the card bridge config group
// Assumes: Config accesses arrive as one-cycle strobes on the PCI clock
// Notes: Offsets are config-space byte addresses
package cbc_pkg;
    localparam logic [7:0] CBC_OFF_INT_PIN = 8'h3D;
    localparam logic [7:0] CBC_OFF_BRIDGE = 8'h3E;
    localparam logic [7:0] CBC_OFF_SUB_VENDOR = 8'h40;
    localparam logic [7:0] CBC_OFF_SUB_ID = 8'h42;
    localparam logic [7:0] CBC_OFF_LEGACY = 8'h44;
    localparam logic [7:0] CBC_OFF_SYS_CTRL = 8'h80;

    localparam int CBC_SYS_TIE_BIT = 29;
    localparam int CBC_SYS_UNLOCK_BIT = 5;
    localparam logic [31:0] CBC_SYS_CTRL_RESET = 32'h0844_9060;

    localparam logic [7:0] CBC_PIN_LINE_A = 8'h01;
    localparam logic [7:0] CBC_PIN_LINE_B = 8'h02;

    localparam logic [15:0] CBC_BRIDGE_RESET = 16'h0340;
    localparam logic [15:0] CBC_BRIDGE_WMASK = 16'h07EF;
    localparam logic [15:0] CBC_SUB_RESET = 16'h0000;
    localparam logic [31:0] CBC_LEGACY_RESET = 32'h0000_0001;
    localparam logic [31:0] CBC_LEGACY_WMASK = 32'hFFFF_FFFE;

    // Bridge control field layout, bit 15 first
    typedef struct packed {
        logic [4:0] rsvd_hi;
        logic write_post_enable;
        logic window1_prefetchable;
        logic window0_prefetchable;
        logic card_irq_route_select;
        logic card_reset_ctl;
        logic master_abort_report_mode;
        logic rsvd_4;
        logic vga_forward_enable;
        logic isa_alias_filter_enable;
        logic card_system_error_forward;
        logic card_parity_error_report;
    } cbc_bridge_t;

    // Configuration access from the host
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cbc_cfg_req_t;

    // Decoded controls toward the data path
    typedef struct packed {
        logic write_post_enable;
        logic window1_prefetchable;
        logic window0_prefetchable;
        logic card_irq_route_select;
        logic master_abort_report_mode;
        logic vga_forward_enable;
        logic isa_alias_filter_enable;
        logic card_system_error_forward;
        logic card_parity_error_report;
    } cbc_ctrl_t;
endpackage
